// ==== verilog/sphr_regs.sv ====
// sphr_regs: host register bank of the serial port, carrier bus slave side
`timescale 1ns/1ps
`default_nettype none
module sphr_regs #(
    parameter int MEM_ADDR_W = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // carrier bus
    input wire logic i_io_sel_n,
    input wire logic i_mem_sel_n,
    input wire logic i_int_sel_n,
    input wire logic i_rd_wr_n,
    input wire logic [1:0] i_byte_sel_n,
    input wire logic [MEM_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic o_data_oe,
    output logic o_ack_n,
    output logic o_int_req_n,
    // control bits kept elsewhere in the device
    input wire logic i_int_en_tx,
    input wire logic i_int_en_rx,
    input wire logic i_int_en_nearly_empty,
    input wire logic i_int_en_nearly_full,
    input wire logic i_int_force,
    input wire logic i_fifo_enable,
    // serial engine events
    input wire logic i_tx_done,
    input wire logic i_rx_done,
    input wire logic i_rx_word_write,
    input wire logic i_rx_parity_mismatch,
    input wire logic i_rx_clk,
    // external queue flags (upper byte chips)
    input wire logic i_tx_queue_full,
    input wire logic i_tx_queue_nearly_empty,
    input wire logic i_tx_queue_half1_empty,
    input wire logic i_tx_queue_half0_empty,
    input wire logic i_rx_queue_half0_full,
    input wire logic i_rx_queue_half1_full,
    input wire logic i_rx_queue_nearly_full,
    input wire logic i_rx_queue_empty,
    // external queue data path
    input wire logic [15:0] i_tx_queue_rdata,
    input wire logic [15:0] i_rx_queue_rdata,
    output logic [15:0] o_queue_wdata,
    output logic o_tx_queue_push,
    output logic o_tx_queue_pop,
    output logic o_rx_queue_push,
    output logic o_rx_queue_pop,
    output logic o_queue_clear,
    output logic o_rx_queue_load_ctl,
    output logic o_tx_queue_load_ctl,
    output logic [MEM_ADDR_W-1:0] o_tx_write_addr,
    output logic o_tx_mem_write,
    // serial side controls
    output logic o_rx_single_ended,
    output logic o_serial_ref,
    output logic o_serial_ref_tick,
    output logic o_rx_word_gap
);
    import sphr_pkg::*;

    sphr_bus_state_t state_reg;
    logic [7:0] upper_control_reg;
    logic [7:0] interrupt_vector_reg;
    logic [7:0] event_status_reg;
    logic [15:0] clock_divider_reg;
    logic [15:0] word_gap_delay_reg;
    logic [11:0] div_count_reg;
    logic div_toggle_reg;
    logic [15:0] gap_count_reg;
    logic int_latch_reg;
    logic [MEM_ADDR_W-1:0] addr_reg;
    logic is_io_reg;
    logic is_mem_reg;
    logic is_ack_cycle_reg;
    logic is_read_reg;
    logic [15:0] read_next;
    logic [6:0] ofs;
    logic take;
    logic io_write;
    logic io_read;
    logic mem_write;
    logic mem_read;
    logic [7:0] status_set;
    logic [7:0] status_clear;
    logic any_condition;

    assign take = (state_reg == SPHR_IDLE) && (!i_io_sel_n || !i_mem_sel_n || !i_int_sel_n);
    assign ofs = {i_addr[5:0], 1'b0};
    assign io_write = take && !i_io_sel_n && !i_rd_wr_n;
    assign io_read = take && !i_io_sel_n && i_rd_wr_n;
    assign mem_write = take && i_io_sel_n && !i_mem_sel_n && !i_rd_wr_n;
    assign mem_read = take && i_io_sel_n && !i_mem_sel_n && i_rd_wr_n;

    // bus cycle: take, one cycle for queue data, ack, then wait for deselect
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= SPHR_IDLE;
        end else begin
            case (state_reg)
                SPHR_IDLE: begin
                    if (take) begin
                        state_reg <= SPHR_LATCH;
                    end
                end
                SPHR_LATCH: state_reg <= SPHR_ACK;
                SPHR_ACK: state_reg <= SPHR_RELEASE;
                SPHR_RELEASE: begin
                    if (i_io_sel_n && i_mem_sel_n && i_int_sel_n) begin
                        state_reg <= SPHR_IDLE;
                    end
                end
                default: state_reg <= SPHR_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_reg <= '0;
            is_io_reg <= 1'b0;
            is_mem_reg <= 1'b0;
            is_ack_cycle_reg <= 1'b0;
            is_read_reg <= 1'b0;
        end else if (take) begin
            addr_reg <= i_addr;
            is_io_reg <= !i_io_sel_n;
            is_mem_reg <= i_io_sel_n && !i_mem_sel_n;
            is_ack_cycle_reg <= i_io_sel_n && i_mem_sel_n;
            is_read_reg <= i_rd_wr_n;
        end
    end

    // queue strobes are one-cycle pulses in the cycle after the access is taken
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_tx_queue_push <= 1'b0;
            o_tx_queue_pop <= 1'b0;
            o_rx_queue_push <= 1'b0;
            o_rx_queue_pop <= 1'b0;
            o_tx_mem_write <= 1'b0;
            o_queue_wdata <= 16'h0000;
            o_tx_write_addr <= '0;
        end else begin
            o_tx_queue_push <= (io_write && ofs == SPHR_OFS_TRANSMIT_QUEUE_WRITE) || mem_write;
            o_tx_mem_write <= mem_write;
            o_tx_queue_pop <= io_read && ofs == SPHR_OFS_TX_LOOPBACK_READ;
            o_rx_queue_push <= io_write && ofs == SPHR_OFS_RX_LOOPBACK_WRITE;
            o_rx_queue_pop <= (io_read && ofs == SPHR_OFS_RECEIVE_QUEUE_READ) || mem_read;
            if (io_write || mem_write) begin
                // programming words pass straight through; flags live in the upper lane
                o_queue_wdata <= i_data;
            end
            if (mem_write) begin
                // the auto-start logic watches this address for message end
                o_tx_write_addr <= i_addr;
            end
        end
    end

    // read data, captured one cycle after the pop so the queue has driven it
    always_comb begin
        read_next = 16'h0000;
        if (is_ack_cycle_reg) begin
            read_next = {8'h00, interrupt_vector_reg};
        end else if (is_mem_reg) begin
            read_next = i_rx_queue_rdata;
        end else if (is_io_reg) begin
            case ({addr_reg[5:0], 1'b0})
                SPHR_OFS_UPPER_CONTROL: read_next = {8'h00, upper_control_reg};
                SPHR_OFS_INTERRUPT_VECTOR: read_next = {8'h00, interrupt_vector_reg};
                SPHR_OFS_FIFO_FLAG_STATUS: read_next = {8'h00, i_tx_queue_full,
                    i_tx_queue_nearly_empty, i_tx_queue_half1_empty, i_tx_queue_half0_empty,
                    i_rx_queue_half0_full, i_rx_queue_half1_full, i_rx_queue_nearly_full,
                    i_rx_queue_empty};
                SPHR_OFS_EVENT_ERROR_STATUS: read_next = {7'h00, any_condition,
                    event_status_reg & SPHR_ST_STORED_MASK};
                SPHR_OFS_SERIAL_CLOCK_DIVIDER: read_next = clock_divider_reg;
                SPHR_OFS_WORD_GAP_DELAY: read_next = word_gap_delay_reg;
                SPHR_OFS_TX_LOOPBACK_READ: read_next = i_tx_queue_rdata;
                SPHR_OFS_RECEIVE_QUEUE_READ: read_next = i_rx_queue_rdata;
                default: read_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_data <= 16'h0000;
        end else if (state_reg == SPHR_LATCH) begin
            o_data <= is_read_reg ? read_next : 16'h0000;
        end
    end

    assign o_ack_n = !(state_reg == SPHR_ACK);
    assign o_data_oe = (state_reg == SPHR_ACK) && is_read_reg;

    // register writes, byte lanes honoured
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            upper_control_reg <= SPHR_UC_RESET;
        end else if (io_write && ofs == SPHR_OFS_UPPER_CONTROL && !i_byte_sel_n[0]) begin
            upper_control_reg <= i_data[7:0] & SPHR_UC_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            interrupt_vector_reg <= SPHR_VECTOR_RESET;
        end else if (io_write && ofs == SPHR_OFS_INTERRUPT_VECTOR && !i_byte_sel_n[0]) begin
            interrupt_vector_reg <= i_data[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            clock_divider_reg <= SPHR_CD_RESET;
        end else if (io_write && ofs == SPHR_OFS_SERIAL_CLOCK_DIVIDER) begin
            // pre-select bits are stored only; the bus clock is always the source
            if (!i_byte_sel_n[1]) begin
                clock_divider_reg[15:8] <= i_data[15:8] & SPHR_CD_MASK[15:8];
            end
            if (!i_byte_sel_n[0]) begin
                clock_divider_reg[7:0] <= i_data[7:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            word_gap_delay_reg <= SPHR_GAP_RESET;
        end else if (io_write && ofs == SPHR_OFS_WORD_GAP_DELAY) begin
            if (!i_byte_sel_n[1]) begin
                word_gap_delay_reg[15:8] <= i_data[15:8];
            end
            if (!i_byte_sel_n[0]) begin
                word_gap_delay_reg[7:0] <= i_data[7:0];
            end
        end
    end

    assign o_rx_single_ended = upper_control_reg[SPHR_UC_SINGLE_ENDED];
    assign o_rx_queue_load_ctl = upper_control_reg[SPHR_UC_RX_LOAD];
    assign o_tx_queue_load_ctl = upper_control_reg[SPHR_UC_TX_LOAD];
    // the load bits must already be high when clear is released for normal writes
    assign o_queue_clear = !i_fifo_enable;

    // event status: set wins over a write-one clear in the same cycle
    always_comb begin
        status_set = 8'h00;
        status_set[SPHR_ST_TX_DONE] = i_tx_done && i_int_en_tx;
        status_set[SPHR_ST_RX_DONE] = i_rx_done && i_int_en_rx;
        status_set[SPHR_ST_NEARLY_EMPTY] = i_tx_queue_nearly_empty && i_int_en_nearly_empty;
        status_set[SPHR_ST_NEARLY_FULL] = i_rx_queue_nearly_full && i_int_en_nearly_full;
        status_set[SPHR_ST_OVERRUN] = i_rx_word_write
            && (i_rx_queue_half0_full || i_rx_queue_half1_full);
        status_set[SPHR_ST_PARITY] = i_rx_parity_mismatch;
    end

    always_comb begin
        status_clear = 8'h00;
        if (io_write && ofs == SPHR_OFS_EVENT_ERROR_STATUS && !i_byte_sel_n[0]) begin
            status_clear = i_data[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            event_status_reg <= 8'h00;
        end else begin
            event_status_reg <= ((event_status_reg & ~status_clear) | status_set)
                & SPHR_ST_STORED_MASK;
        end
    end

    assign any_condition = |event_status_reg[3:0] || i_int_force;

    // holding latch: a fresh event arms it, acknowledge or master disable drops it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            int_latch_reg <= 1'b0;
        end else if (take && !i_int_sel_n) begin
            int_latch_reg <= 1'b0;
        end else if (|(status_set[3:0] & ~event_status_reg[3:0])) begin
            int_latch_reg <= 1'b1;
        end else if (!upper_control_reg[SPHR_UC_MASTER_INT] || !(|event_status_reg[3:0])) begin
            int_latch_reg <= 1'b0;
        end
    end

    // force stays a level while set, as software removes it itself
    assign o_int_req_n = !(upper_control_reg[SPHR_UC_MASTER_INT]
        && (int_latch_reg || i_int_force));

    // serial reference divider, counts 0..n then toggles
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_count_reg <= 12'h000;
            div_toggle_reg <= 1'b0;
        end else if (div_count_reg >= clock_divider_reg[11:0]) begin
            div_count_reg <= 12'h000;
            div_toggle_reg <= !div_toggle_reg;
        end else begin
            div_count_reg <= div_count_reg + 12'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_serial_ref <= 1'b0;
            o_serial_ref_tick <= 1'b0;
        end else if (clock_divider_reg[SPHR_CD_POST_SEL]) begin
            o_serial_ref <= div_toggle_reg;
            o_serial_ref_tick <= div_count_reg >= clock_divider_reg[11:0];
        end else begin
            // undivided source: a tick on every bus clock
            o_serial_ref <= !o_serial_ref;
            o_serial_ref_tick <= 1'b1;
        end
    end

    // word gap: bus clocks counted while the received clock stays high
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            gap_count_reg <= 16'h0000;
            o_rx_word_gap <= 1'b0;
        end else if (!i_rx_clk) begin
            gap_count_reg <= 16'h0000;
            o_rx_word_gap <= 1'b0;
        end else begin
            if (gap_count_reg != 16'hffff) begin
                gap_count_reg <= gap_count_reg + 16'h0001;
            end
            o_rx_word_gap <= gap_count_reg >= word_gap_delay_reg;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/sphr_pkg.sv ====
// sphr_pkg: constants for the serial port host register bank
// Summary of operation
// - control bit 0 picks single-ended receive inputs
// - control bits 5,4 drive queue load pins
// - flags default seven words from full/empty
// - master enable gates every outgoing interrupt request
// - vector byte, low lane, resets to 0xff
// - interrupt acknowledge withdraws the pending request
// - flag status reports queue flags active high
// - event bits set when individually enabled
// - overrun and parity errors set, reception continues
// - bit 8 any condition; bits 5,4 zero
// - writing one clears an event status bit
// - clock pre-select stored, no effect
// - bit 12 picks divided or source reference
// - 12-bit divider gives source over 2(n+1)
// - gap delay counts bus clocks clock high
// - queue port or memory writes push transmit
// - loop-back read pops transmit queue word
// - loop-back write pushes receive queue word
// - queue port or memory reads pop receive
// - flag programming uses upper byte lane only
// - fifo enable low holds both queues cleared
package sphr_pkg;
    // byte offsets in the i/o space
    localparam logic [6:0] SPHR_OFS_UPPER_CONTROL = 7'h04;
    localparam logic [6:0] SPHR_OFS_INTERRUPT_VECTOR = 7'h06;
    localparam logic [6:0] SPHR_OFS_FIFO_FLAG_STATUS = 7'h08;
    localparam logic [6:0] SPHR_OFS_EVENT_ERROR_STATUS = 7'h0a;
    localparam logic [6:0] SPHR_OFS_TRANSMIT_QUEUE_WRITE = 7'h10;
    localparam logic [6:0] SPHR_OFS_SERIAL_CLOCK_DIVIDER = 7'h16;
    localparam logic [6:0] SPHR_OFS_WORD_GAP_DELAY = 7'h1e;
    localparam logic [6:0] SPHR_OFS_RX_LOOPBACK_WRITE = 7'h20;
    localparam logic [6:0] SPHR_OFS_TX_LOOPBACK_READ = 7'h22;
    localparam logic [6:0] SPHR_OFS_RECEIVE_QUEUE_READ = 7'h40;
    // upper control fields
    localparam int SPHR_UC_SINGLE_ENDED = 0;
    localparam int SPHR_UC_TX_LOAD = 4;
    localparam int SPHR_UC_RX_LOAD = 5;
    localparam int SPHR_UC_MASTER_INT = 6;
    localparam logic [7:0] SPHR_UC_RESET = 8'h00;
    localparam logic [7:0] SPHR_UC_MASK = 8'h71;
    // event/error status fields
    localparam int SPHR_ST_TX_DONE = 0;
    localparam int SPHR_ST_RX_DONE = 1;
    localparam int SPHR_ST_NEARLY_EMPTY = 2;
    localparam int SPHR_ST_NEARLY_FULL = 3;
    localparam int SPHR_ST_OVERRUN = 6;
    localparam int SPHR_ST_PARITY = 7;
    localparam int SPHR_ST_INT_REQUEST = 8;
    localparam logic [7:0] SPHR_ST_STORED_MASK = 8'hcf;
    // clock divider fields
    localparam int SPHR_CD_POST_SEL = 12;
    localparam int SPHR_CD_PRE_LSB = 13;
    localparam logic [15:0] SPHR_CD_RESET = 16'h0000;
    localparam logic [15:0] SPHR_CD_MASK = 16'h7fff;
    localparam logic [15:0] SPHR_GAP_RESET = 16'h0000;
    localparam logic [7:0] SPHR_VECTOR_RESET = 8'hff;
    // default flag distance inside the external queues
    localparam int SPHR_FLAG_DEFAULT_DISTANCE = 7;
    // bus cycle sequencing
    typedef enum logic [1:0] {
        SPHR_IDLE,
        SPHR_LATCH,
        SPHR_ACK,
        SPHR_RELEASE
    } sphr_bus_state_t;
endpackage

// ==== test/sphr_regs_checker.sv ====
// assertions on the host bus cycle and queue strobes of the register bank
`timescale 1ns/1ps
`default_nettype none
module sphr_regs_checker #(
    parameter int MEM_ADDR_W = 8
) (
    input wire logic i_clk, i_srst, i_io_sel_n, i_mem_sel_n, i_int_sel_n, i_rd_wr_n,
    input wire logic i_int_force, i_fifo_enable, o_ack_n, o_data_oe, o_int_req_n,
    input wire logic o_queue_clear, o_tx_queue_push, o_tx_queue_pop, o_rx_queue_push,
    input wire logic o_rx_queue_pop, o_tx_mem_write,
    input wire logic [MEM_ADDR_W-1:0] i_addr, o_tx_write_addr,
    input wire logic [15:0] i_data, o_queue_wdata
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    sequence any_take;
        $fell(i_io_sel_n & i_mem_sel_n & i_int_sel_n);
    endsequence
    sequence io_take;
        $fell(i_io_sel_n) && i_mem_sel_n && i_int_sel_n;
    endsequence
    sequence mem_take;
        $fell(i_mem_sel_n) && i_io_sel_n;
    endsequence
    sequence int_take;
        $fell(i_int_sel_n) && i_io_sel_n && i_mem_sel_n;
    endsequence
    sequence ack_pulse;
        o_ack_n [*2] ##1 !o_ack_n ##1 o_ack_n;
    endsequence
    ack_timing_a: assert property (any_take |-> ack_pulse)
        else $error("acknowledge not a single cycle two edges after take");
    read_drive_a: assert property ((o_data_oe || !o_ack_n) |->
        o_data_oe == (!o_ack_n && i_rd_wr_n)) else $error("read drive enable wrong");
    queue_clear_a: assert property (o_queue_clear == !i_fifo_enable)
        else $error("queue clear does not follow enable");
    intack_clear_a: assert property (int_take ##0 !i_int_force |=> o_int_req_n)
        else $error("request kept after acknowledge");
    tx_push_a: assert property (io_take ##0 (!i_rd_wr_n && i_addr[5:0] == 6'h08) |=>
        o_tx_queue_push && o_queue_wdata == $past(i_data) ##1 !o_tx_queue_push)
        else $error("transmit push missing");
    mem_write_a: assert property (mem_take ##0 !i_rd_wr_n |=>
        o_tx_queue_push && o_tx_mem_write && o_tx_write_addr == $past(i_addr))
        else $error("memory write push missing");
    rx_pop_a: assert property ((io_take ##0 (i_rd_wr_n && i_addr[5:0] == 6'h20)) or
        (mem_take ##0 i_rd_wr_n) |=> o_rx_queue_pop ##1 !o_rx_queue_pop)
        else $error("receive pop missing");
    tx_pop_a: assert property (io_take ##0 (i_rd_wr_n && i_addr[5:0] == 6'h11) |=>
        o_tx_queue_pop && !o_rx_queue_pop) else $error("loop-back pop missing");
    rx_push_a: assert property (io_take ##0 (!i_rd_wr_n && i_addr[5:0] == 6'h10) |=>
        o_rx_queue_push && !o_tx_queue_push && o_queue_wdata == $past(i_data))
        else $error("loop-back push missing");
endmodule
bind sphr_regs sphr_regs_checker #(.MEM_ADDR_W(MEM_ADDR_W)) u_chk (.*);
`default_nettype wire

// ==== test/sphr_host_model.sv ====
// host processor model: carrier bus cycles and queue enable sequencing
`timescale 1ns/1ps
`default_nettype none
module sphr_host_model (
    input wire logic i_clk,
    input wire logic i_ack_n,
    input wire logic [15:0] i_data,
    output logic o_io_sel_n, o_mem_sel_n, o_int_sel_n, o_rd_wr_n, o_fifo_enable,
    output logic [1:0] o_byte_sel_n,
    output logic [7:0] o_addr,
    output logic [15:0] o_data
);
    int misses = 0;
    initial begin
        {o_io_sel_n, o_mem_sel_n, o_int_sel_n, o_rd_wr_n, o_fifo_enable} = 5'h1e;
        o_byte_sel_n = 2'b11;
        o_addr = 8'h00;
        o_data = 16'h0000;
    end
    // kind 0 io, 1 memory, 2 interrupt acknowledge; all held until ack is sampled
    task automatic access(input int kind, input logic rd, input logic [7:0] a,
            input logic [15:0] wd, input logic [1:0] be_n, output logic [15:0] rdat);
        int n;
        n = 0;
        @(posedge i_clk);
        o_rd_wr_n <= rd;
        o_addr <= a;
        o_data <= wd;
        o_byte_sel_n <= be_n;
        o_io_sel_n <= kind != 0;
        o_mem_sel_n <= kind != 1;
        o_int_sel_n <= kind != 2;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_ack_n !== 1'b0 && n < 16);
        misses += int'(n >= 16);
        rdat = i_data;
        {o_io_sel_n, o_mem_sel_n, o_int_sel_n} <= 3'h7;
        // a released bus must not keep looking like the last word
        o_data <= ~wd;
        @(posedge i_clk);
    endtask
    task automatic restart(input logic [7:0] uc);
        logic [15:0] d;
        access(0, 1'b0, 8'h02, {8'h00, uc}, 2'b10, d);
        @(posedge i_clk) o_fifo_enable <= 1'b1;
        @(posedge i_clk) o_fifo_enable <= 1'b0;
        @(posedge i_clk) o_fifo_enable <= 1'b1;
        @(posedge i_clk);
    endtask
    // levels go in on the upper lane only; serial reception is idle meanwhile
    task automatic prog_levels(input logic [15:0] ae, input logic [15:0] af);
        logic [15:0] d;
        restart(8'h00);
        access(0, 1'b0, 8'h10, {ae[7:0], 8'h00}, 2'b00, d);
        access(0, 1'b0, 8'h10, {ae[15:8], 8'h00}, 2'b00, d);
        access(0, 1'b0, 8'h10, {af[7:0], 8'h00}, 2'b00, d);
        access(0, 1'b0, 8'h10, {af[15:8], 8'h00}, 2'b00, d);
        access(0, 1'b0, 8'h02, 16'h0030, 2'b10, d);
    endtask
endmodule
`default_nettype wire

// ==== test/tb_serial_port_host_registers.sv ====
// self-checking bench of the serial port host register bank
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_host_registers;
    import sphr_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_io_sel_n, i_mem_sel_n, i_int_sel_n, i_rd_wr_n, i_fifo_enable, i_int_force, i_rx_clk;
    logic [1:0] i_byte_sel_n;
    logic [7:0] i_addr, flags, f, o_tx_write_addr;
    logic [3:0] en, ev;
    logic [15:0] i_data, i_tx_queue_rdata, i_rx_queue_rdata, o_data, o_queue_wdata, rd, v, vec;
    logic o_data_oe, o_ack_n, o_int_req_n, o_tx_queue_push, o_tx_queue_pop, o_rx_queue_push;
    logic o_rx_queue_pop, o_queue_clear, o_rx_queue_load_ctl, o_tx_queue_load_ctl, o_tx_mem_write;
    logic o_rx_single_ended, o_serial_ref, o_serial_ref_tick, o_rx_word_gap;
    int failures = 0;
    int samples_checked = 0;
    int c, n;
    sphr_regs dut (.*, .i_int_en_tx(en[0]), .i_int_en_rx(en[1]), .i_int_en_nearly_empty(en[2]),
        .i_int_en_nearly_full(en[3]), .i_tx_done(ev[0]), .i_rx_done(ev[1]),
        .i_rx_word_write(ev[2]), .i_rx_parity_mismatch(ev[3]), .i_tx_queue_full(flags[7]),
        .i_tx_queue_nearly_empty(flags[6]), .i_tx_queue_half1_empty(flags[5]),
        .i_tx_queue_half0_empty(flags[4]), .i_rx_queue_half0_full(flags[3]),
        .i_rx_queue_half1_full(flags[2]), .i_rx_queue_nearly_full(flags[1]),
        .i_rx_queue_empty(flags[0]));
    sphr_host_model host (.i_clk(i_clk), .i_ack_n(o_ack_n), .i_data(o_data),
        .o_io_sel_n(i_io_sel_n), .o_mem_sel_n(i_mem_sel_n), .o_int_sel_n(i_int_sel_n),
        .o_rd_wr_n(i_rd_wr_n), .o_fifo_enable(i_fifo_enable), .o_byte_sel_n(i_byte_sel_n),
        .o_addr(i_addr), .o_data(i_data));
    always #2 i_clk = ~i_clk;
    function automatic logic [15:0] ev_stat(input int i);
        return 16'h0100 | (16'h0001 << i);
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] e);
        samples_checked++;
        if (seen !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] ofs, input logic [15:0] m,
            input logic [15:0] e);
        logic [15:0] r;
        host.access(0, 1'b1, ofs >> 1, 16'h0000, 2'b00, r);
        check(nm, r & m, e);
    endtask
    task automatic wreg(input logic [7:0] ofs, input logic [15:0] d, input logic [1:0] be_n);
        logic [15:0] r;
        host.access(0, 1'b0, ofs >> 1, d, be_n, r);
    endtask
    task automatic trig(input logic [3:0] m, input logic [7:0] fl);
        @(posedge i_clk) ev <= m;
        flags <= fl;
        @(posedge i_clk) ev <= 4'h0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic wait_ref(input logic lv, inout int cnt);
        int k;
        k = 0;
        while (o_serial_ref !== lv && k < 200) begin
            @(posedge i_clk);
            cnt++;
            k++;
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100us;
        failures++;
        end_sim();
    end
    initial begin
        void'($urandom(13));
        {i_int_force, i_rx_clk, en, ev, flags} = '0;
        {i_tx_queue_rdata, i_rx_queue_rdata} = '0;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        rchk("control", 8'h04, 16'h00ff, 16'h0000);
        rchk("vector", 8'h06, 16'h00ff, 16'h00ff);
        rchk("events", 8'h0a, 16'hffff, 16'h0000);
        check("int_idle", o_int_req_n, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom) & 16'h00bf;
            wreg(8'h04, v, 2'b10);
            check("single_ended", o_rx_single_ended, v[0]);
            check("load_ctl", {o_rx_queue_load_ctl, o_tx_queue_load_ctl}, v[5:4]);
            rchk("control", 8'h04, 16'h00ff, v & 16'h0031);
        end
        vec = 16'($urandom);
        wreg(8'h06, vec, 2'b10);
        rchk("vector", 8'h06, 16'h00ff, vec & 16'h00ff);
        repeat (4) begin
            f = 8'($urandom);
            @(posedge i_clk) flags <= f;
            rchk("flags", 8'h08, 16'h00ff, {8'h00, f});
        end
        wreg(8'h30, 16'hffff, 2'b00);
        rchk("unmapped", 8'h30, 16'hffff, 16'h0000);
        host.prog_levels(16'h0020, 16'h0030);
        host.restart(8'h30);
        check("queue_run", {o_queue_clear, o_rx_queue_load_ctl, o_tx_queue_load_ctl}, 16'h0003);
        v = 16'($urandom);
        @(posedge i_clk) i_rx_queue_rdata <= v;
        i_tx_queue_rdata <= ~v;
        rchk("rx_queue", 8'h40, 16'hffff, v);
        rchk("tx_loop", 8'h22, 16'hffff, ~v);
        host.access(1, 1'b1, 8'($urandom), 16'h0000, 2'b00, rd);
        check("mem_read", rd, v);
        host.access(1, 1'b0, 8'($urandom), v, 2'b00, rd);
        wreg(8'h10, ~v, 2'b00);
        trig(4'b1101, 8'h08);
        rchk("errors", 8'h0a, 16'hffff, 16'h00c0);
        wreg(8'h0a, 16'h0000, 2'b00);
        rchk("keep", 8'h0a, 16'hffff, 16'h00c0);
        wreg(8'h0a, 16'h0040, 2'b00);
        rchk("clear_one", 8'h0a, 16'hffff, 16'h0080);
        wreg(8'h0a, 16'h0080, 2'b00);
        for (int m = 0; m < 2; m++) begin
            wreg(8'h04, (m == 1) ? 16'h0070 : 16'h0030, 2'b10);
            for (int i = 0; i < 4; i++) begin
                @(posedge i_clk) en <= 4'(1 << i);
                trig(4'(i < 2 ? 1 << i : 0), (i == 2) ? 8'h40 : ((i == 3) ? 8'h02 : 8'h00));
                rchk("event", 8'h0a, 16'hffff, ev_stat(i));
                check("int_req", o_int_req_n, 16'(m == 0));
                host.access(2, 1'b1, 8'h00, 16'h0000, 2'b00, rd);
                check("ack_vector", rd & 16'h00ff, vec & 16'h00ff);
                check("int_drop", o_int_req_n, 16'h0001);
                trig(4'h0, 8'h00);
                wreg(8'h0a, 16'h000f, 2'b00);
                rchk("cleared", 8'h0a, 16'hffff, 16'h0000);
            end
        end
        @(posedge i_clk) i_int_force <= 1'b1;
        en <= 4'h0;
        rchk("forced", 8'h0a, 16'hffff, 16'h0100);
        check("force_req", o_int_req_n, 16'h0000);
        @(posedge i_clk) i_int_force <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 1 : 2 + $urandom % 8;
            v = {1'b0, 2'($urandom), 1'b1, 12'(n)};
            wreg(8'h16, v, 2'b00);
            rchk("divider", 8'h16, 16'hffff, v);
            c = 0;
            wait_ref(1'b0, c);
            wait_ref(1'b1, c);
            c = 0;
            wait_ref(1'b0, c);
            wait_ref(1'b1, c);
            check("period", 16'(c), 16'(2 * (n + 1)));
        end
        wreg(8'h16, 16'h0005, 2'b00);
        repeat (4) @(posedge i_clk) check("tick", o_serial_ref_tick, 16'h0001);
        wreg(8'h1e, 16'h0006, 2'b00);
        rchk("gap", 8'h1e, 16'hffff, 16'h0006);
        @(posedge i_clk) i_rx_clk <= 1'b1;
        c = 0;
        while (o_rx_word_gap !== 1'b1 && c < 50) begin
            @(posedge i_clk);
            c++;
        end
        check("gap_wait", 16'(c), 16'h0008);
        @(posedge i_clk) i_rx_clk <= 1'b0;
        repeat (3) @(posedge i_clk);
        check("gap_end", o_rx_word_gap, 16'h0000);
        check("bus_misses", 16'(host.misses), 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
